// [pib_pkg.sv]
// Shared constants and types for the power and interrupt register bank link.
package pib_pkg;

  localparam int CLK_PERIOD_NS = 50;
  localparam int SLEEP_TIMEOUT_NS = 1000000;
  localparam int SLEEP_CYC = SLEEP_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int WAKE_PULSE_NS = 4000;
  localparam int WAKE_CYC = (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUARTER_CYC = 5;

  localparam logic [7:0] SLAVE_ADDR_BYTE = 8'h90;
  localparam logic [7:0] REG_INERTIAL = 8'h00;
  localparam logic [7:0] REG_ENVIRONMENT = 8'h01;
  localparam logic [7:0] REG_MICROPHONE = 8'h02;
  localparam logic [7:0] REG_AIR_QUALITY = 8'h03;
  localparam logic [7:0] REG_LED = 8'h04;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h05;
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h06;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h07;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int NUM_CTRL = 6;
  localparam logic [7:0] WMASK [0:NUM_CTRL-1] = '{8'h01, 8'h01, 8'h01, 8'h03, 8'hf1, 8'h07};
  localparam int BIT_POWER = 0;
  localparam int BIT_AQ_WAKE = 1;
  localparam int LED_EN_LSB = 4;
  localparam int NUM_IRQ = 3;

  localparam int AXI_ADDR_W = 4;
  localparam logic [AXI_ADDR_W-1:0] CMD_OFS = 4'h0;
  localparam logic [AXI_ADDR_W-1:0] STAT_OFS = 4'h4;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WAKE = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] WR_STOP_STEP = 3'h4;
  localparam logic [2:0] RD_STOP_STEP = 3'h6;
  localparam logic [2:0] RD_DATA_STEP = 3'h5;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_RX = 3'b001,
    D_ACK = 3'b011,
    D_TX = 3'b010,
    D_MACK = 3'b110,
    D_WAIT = 3'b111
  } pib_dev_state_e;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_WAKE = 2'b01,
    H_RUN = 2'b11
  } pib_host_state_e;

  typedef enum logic [1:0] {
    SYM_START = 2'b00,
    SYM_BYTE = 2'b01,
    SYM_STOP = 2'b11
  } pib_sym_e;

endpackage

// [pib_if.sv]
// Open-drain bus, clock and wake lines shared by the host and the controller.
`timescale 1ns/1ns
interface pib_if;
  logic host_scl_o;
  logic host_scl_oen;
  logic host_sda_o;
  logic host_sda_oen;
  logic host_wake_o;
  logic host_wake_oen;
  logic dev_sda_o;
  logic dev_sda_oen;
  logic dev_wake_o;
  logic dev_wake_oen;
  logic scl;
  logic sda;
  logic wake;

  // Pull-ups make a released line read high; any driver pulls it low.
  assign scl = host_scl_oen | host_scl_o;
  assign sda = (host_sda_oen | host_sda_o) & (dev_sda_oen | dev_sda_o);
  assign wake = (host_wake_oen | host_wake_o) & (dev_wake_oen | dev_wake_o);

  modport dev (
    input scl, sda, wake,
    output dev_sda_o, dev_sda_oen, dev_wake_o, dev_wake_oen
  );

  modport host (
    input sda, wake,
    output host_scl_o, host_scl_oen, host_sda_o, host_sda_oen, host_wake_o, host_wake_oen
  );
endinterface

// [pib_sync.sv]
// Two-flop synchroniser for inputs that come from outside the clock domain.
`timescale 1ns/1ns
module pib_sync
  import pib_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        meta[i] <= RST_VAL[i];
        q[i] <= RST_VAL[i];
      end
      else
      begin
        meta[i] <= d[i];
        q[i] <= meta[i];
      end
    end
  end
endmodule

// [pib_device.sv]
// Controller end: wakeable bus slave with power control and interrupt flag registers.
// Operation
// R1 - Wake and enable slave on wake falling edge.
// R2 - Ignore and never acknowledge bus while asleep.
// R3 - Stay awake while low, then 1 ms.
// R4 - Bus activity restarts the 1 ms sleep timeout.
// R5 - Host holds wake low at least 4 us.
// R6 - Host re-wakes unless next transfer within 1 ms.
// R7 - Both drive wake line open drain, wired-AND.
// R8 - Write: address 0x90, register byte, data byte.
// R9 - Read: set pointer, then restart or new transfer.
// R10 - Register 0 bit 0 powers inertial sensor.
// R11 - Register 1 bit 0 powers environment group.
// R12 - Register 2 bit 0 powers microphone path.
// R13 - Register 3 powers and wakes air-quality sensor.
// R14 - Register 4 enables regulator and four LEDs.
// R15 - Register 5 holds one enable per source.
// R16 - Register 6 clears matching status flags.
// R17 - Register 7 reports flags; all reset zero.
// R18 - Latched mode holds wake low while flagged.
// R19 - Flag set by source, held until cleared.
// R20 - Only written ones clear flags.
`timescale 1ns/1ns
module pib_device
  import pib_pkg::*;
#(
  parameter int SLEEP_CYCLES = SLEEP_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  pib_if.dev bus,
  input wire logic [NUM_IRQ-1:0] irq_src,
  input wire logic latched_mode,
  output logic awake,
  output logic inertial_power,
  output logic environment_power,
  output logic microphone_power,
  output logic air_quality_power,
  output logic air_quality_wake,
  output logic led_regulator_en,
  output logic [3:0] led_en
);

  localparam int CW = $clog2(SLEEP_CYCLES + 1);

  if (SLEEP_CYCLES < 2)
  begin : g_chk
    $error("SLEEP_CYCLES must be at least 2");
  end

  logic [NUM_IRQ+2:0] syn;
  logic scl_s;
  logic sda_s;
  logic wake_s;
  logic [NUM_IRQ-1:0] irq_s;
  logic scl_d;
  logic sda_d;
  logic wake_d;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic bus_act;
  logic wake_fall;
  logic [CW-1:0] idle_cnt;
  pib_dev_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] txsh;
  logic [1:0] byte_idx;
  logic reading;
  logic [7:0] ptr;
  logic byte_done;
  logic wr_en;
  logic [7:0] rd_byte;
  logic [7:0] ctrl [0:NUM_CTRL-1];
  logic [NUM_IRQ-1:0] flags;
  logic [NUM_IRQ-1:0] clr;
  logic next_sda_oen;

  ////////////////////////////////////////////////////////////////////////////
  // Bus, wake and interrupt source lines are synchronised, latched_mode is not; edges use a third stage only.
  pib_sync #(
    .W(NUM_IRQ + 3),
    .RST_VAL(6'h07)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({irq_src, bus.wake, bus.sda, bus.scl}),
    .q(syn)
  );

  assign scl_s = syn[0];
  assign sda_s = syn[1];
  assign wake_s = syn[2];
  assign irq_s = syn[NUM_IRQ+2:3];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      wake_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      wake_d <= wake_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
  assign bus_act = (scl_s ^ scl_d) | (sda_s ^ sda_d);
  assign wake_fall = wake_d & ~wake_s;

  ////////////////////////////////////////////////////////////////////////////
  // Sleep control. The timer is reloaded as long as the line is low or the bus moves.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      idle_cnt <= '0;
    else if (wake_fall || !wake_s || bus_act) // R3 R4
      idle_cnt <= CW'(SLEEP_CYCLES - 1);
    else if (idle_cnt != '0)
      idle_cnt <= idle_cnt - CW'(1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      awake <= 1'b0;
    else if (wake_fall) // R1
      awake <= 1'b1;
    else if (wake_s && idle_cnt == '0) // R3
      awake <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave. Sleep forces the idle state, so nothing is acknowledged then.
  assign byte_done = awake && state == D_RX && scl_fall && bit_cnt == 4'h8;
  assign wr_en = byte_done && byte_idx == 2'h2; // R8

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= D_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      txsh <= 8'h00;
      byte_idx <= 2'h0;
      reading <= 1'b0;
      ptr <= 8'h00;
    end
    else if (!awake)
      state <= D_IDLE; // R2
    else if (start_c) // R9
    begin
      state <= D_RX;
      bit_cnt <= 4'h0;
      byte_idx <= 2'h0;
    end
    else if (stop_c)
      state <= D_IDLE;
    else
    begin
      case (state)
        D_RX:
        begin
          if (scl_rise)
          begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (byte_done)
          begin
            if (byte_idx != 2'h2)
              byte_idx <= byte_idx + 2'h1;
            if (byte_idx == 2'h0 && shreg[7:1] != SLAVE_ADDR_BYTE[7:1]) // R8
              state <= D_WAIT;
            else
              state <= D_ACK;
            if (byte_idx == 2'h0)
              reading <= shreg[0]; // R9
            if (byte_idx == 2'h1)
              ptr <= shreg; // R9
          end
        end
        D_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt <= 4'h0;
            txsh <= rd_byte;
            state <= reading ? D_TX : D_RX;
          end
        end
        D_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt == 4'h7)
              state <= D_MACK;
            else
            begin
              txsh <= {txsh[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        D_MACK:
        begin
          // A refused byte ends the read; an accepted one sends the register again.
          if (scl_rise && sda_s)
            state <= D_WAIT;
          else if (scl_fall)
          begin
            state <= D_TX;
            bit_cnt <= 4'h0;
            txsh <= rd_byte;
          end
        end
        default:
          state <= state;
      endcase
    end
  end

  always_comb
  begin
    next_sda_oen = 1'b1;
    if (state == D_ACK)
      next_sda_oen = 1'b0;
    else if (state == D_TX)
      next_sda_oen = txsh[7];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bus.dev_sda_oen <= 1'b1;
    else
      bus.dev_sda_oen <= next_sda_oen;
  end

  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_wake_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Register file. Reserved bits are not stored and read back as zero.
  for (genvar i = 0; i < NUM_CTRL; i++)
  begin : g_ctrl
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        ctrl[i] <= REG_RESET; // R17
      else if (wr_en && ptr == 8'(i))
        ctrl[i] <= shreg & WMASK[i]; // R10 R11 R12 R13 R14 R15
    end
  end

  always_comb
  begin
    rd_byte = 8'h00;
    if (ptr < REG_IRQ_CLEAR)
      rd_byte = ctrl[ptr[2:0]];
    else if (ptr == REG_IRQ_STATUS)
      rd_byte = {5'h00, flags}; // R17
  end

  assign clr = (wr_en && ptr == REG_IRQ_CLEAR) ? shreg[NUM_IRQ-1:0] : '0; // R16 R20

  // A source still active in the clearing cycle sets its flag again.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags <= '0;
    else
      flags <= (flags & ~clr) | irq_s; // R19 R20
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bus.dev_wake_oen <= 1'b1;
    else
      bus.dev_wake_oen <= ~(latched_mode & |(flags & ctrl[5][NUM_IRQ-1:0])); // R18 R7
  end

  assign inertial_power = ctrl[0][BIT_POWER]; // R10
  assign environment_power = ctrl[1][BIT_POWER]; // R11
  assign microphone_power = ctrl[2][BIT_POWER]; // R12
  assign air_quality_power = ctrl[3][BIT_POWER]; // R13
  assign air_quality_wake = ctrl[3][BIT_AQ_WAKE]; // R13
  assign led_regulator_en = ctrl[4][BIT_POWER]; // R14
  assign led_en = ctrl[4][LED_EN_LSB+3:LED_EN_LSB]; // R14
endmodule

// [pib_host.sv]
// Host end: AXI4-Lite command registers driving wake pulses and bus transfers.
`timescale 1ns/1ns
module pib_host
  import pib_pkg::*;
#(
  parameter int QUARTER_CYCLES = QUARTER_CYC,
  parameter int WAKE_CYCLES = WAKE_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  pib_if.host bus
);

  if (QUARTER_CYCLES < 2 || QUARTER_CYCLES > 255 || WAKE_CYCLES < 1 || WAKE_CYCLES > 255)
  begin : g_chk
    $error("QUARTER_CYCLES and WAKE_CYCLES must fit an 8-bit counter");
  end

  logic [1:0] syn;
  logic sda_s;
  logic wake_s;
  pib_host_state_e state;
  logic [1:0] op;
  logic [7:0] reg_a;
  logic [7:0] wdat;
  logic [7:0] rxb;
  logic [7:0] tcnt;
  logic [1:0] q;
  logic [2:0] step;
  logic [3:0] bitn;
  logic nack;
  logic wr_take;
  logic cmd_go;
  logic rd;
  logic rx_byte;
  logic [9:0] info;
  logic [7:0] bit_sh;

  function automatic logic [9:0] step_info(input logic r, input logic [2:0] st,
                                           input logic [7:0] ra, input logic [7:0] wd);
    logic [9:0] v;
    case ({r, st})
      4'h0, 4'h8, 4'hb: v = {SYM_START, 8'h00};
      4'h1, 4'h9: v = {SYM_BYTE, SLAVE_ADDR_BYTE};
      4'h2, 4'ha: v = {SYM_BYTE, ra};
      4'h3: v = {SYM_BYTE, wd};
      4'hc: v = {SYM_BYTE, SLAVE_ADDR_BYTE | 8'h01};
      4'hd: v = {SYM_BYTE, 8'hff};
      default: v = {SYM_STOP, 8'h00};
    endcase
    return v;
  endfunction

  pib_sync #(
    .W(2),
    .RST_VAL(2'h3)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({bus.wake, bus.sda}),
    .q(syn)
  );

  assign sda_s = syn[0];
  assign wake_s = syn[1];

  ////////////////////////////////////////////////////////////////////////////
  // Register slave. Address and data are taken together; commands while busy are dropped.
  assign wr_take = awvalid & wvalid & ~bvalid;
  assign awready = wr_take;
  assign wready = wr_take;
  assign arready = ~rvalid;
  assign cmd_go = wr_take && awaddr == CMD_OFS && wstrb[2:0] == 3'h7 &&
                  state == H_IDLE && wdata[1:0] != 2'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (wr_take)
    begin
      bvalid <= 1'b1;
      bresp <= (awaddr == CMD_OFS) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end
    else if (arvalid && !rvalid)
    begin
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      if (araddr == CMD_OFS)
        rdata <= {8'h00, wdat, reg_a, 6'h00, op};
      else if (araddr == STAT_OFS)
        rdata <= {16'h0000, rxb, 5'h00, ~wake_s, nack, state != H_IDLE};
      else
      begin
        rdata <= 32'h0000_0000;
        rresp <= RESP_SLVERR;
      end
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer engine. A start, a stop and each of the nine bits of a byte take four quarter periods of the bus clock.
  assign rd = op == OP_READ;
  assign rx_byte = rd && step == RD_DATA_STEP;
  assign info = step_info(rd, step, reg_a, wdat);
  assign bit_sh = info[7:0] << bitn[2:0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= H_IDLE;
      op <= 2'h0;
      reg_a <= 8'h00;
      wdat <= 8'h00;
      rxb <= 8'h00;
      tcnt <= 8'h00;
      q <= 2'h0;
      step <= 3'h0;
      bitn <= 4'h0;
      nack <= 1'b0;
      bus.host_scl_oen <= 1'b1;
      bus.host_sda_oen <= 1'b1;
      bus.host_wake_oen <= 1'b1;
    end
    else
    begin
      case (state)
        H_IDLE:
        begin
          if (cmd_go)
          begin
            op <= wdata[1:0];
            reg_a <= wdata[15:8];
            wdat <= wdata[23:16];
            nack <= 1'b0;
            tcnt <= 8'h00;
            state <= H_WAKE;
            bus.host_wake_oen <= 1'b0; // R5 R7
          end
        end
        H_WAKE:
        begin
          if (tcnt == 8'(WAKE_CYCLES - 1)) // R5
          begin
            bus.host_wake_oen <= 1'b1;
            tcnt <= 8'h00;
            q <= 2'h0;
            step <= 3'h0;
            bitn <= 4'h0;
            state <= (op == OP_WAKE) ? H_IDLE : H_RUN; // R6
          end
          else
            tcnt <= tcnt + 8'h01;
        end
        H_RUN:
        begin
          if (tcnt != 8'(QUARTER_CYCLES - 1))
            tcnt <= tcnt + 8'h01;
          else
          begin
            tcnt <= 8'h00;
            q <= q + 2'h1;
            if (info[9:8] == SYM_START) // R9
            begin
              case (q)
                2'h0: bus.host_sda_oen <= 1'b1;
                2'h1: bus.host_scl_oen <= 1'b1;
                2'h2: bus.host_sda_oen <= 1'b0;
                default:
                begin
                  bus.host_scl_oen <= 1'b0;
                  step <= step + 3'h1;
                end
              endcase
            end
            else if (info[9:8] == SYM_BYTE) // R8
            begin
              case (q)
                2'h0: bus.host_sda_oen <= (bitn < 4'h8) ? bit_sh[7] : 1'b1;
                2'h1: bus.host_scl_oen <= 1'b1;
                2'h2: bus.host_scl_oen <= 1'b1;
                default:
                begin
                  bus.host_scl_oen <= 1'b0;
                  if (bitn < 4'h8)
                  begin
                    bitn <= bitn + 4'h1;
                    if (rx_byte)
                      rxb <= {rxb[6:0], sda_s};
                  end
                  else
                  begin
                    bitn <= 4'h0;
                    if (sda_s && !rx_byte)
                    begin
                      nack <= 1'b1;
                      step <= rd ? RD_STOP_STEP : WR_STOP_STEP;
                    end
                    else
                      step <= step + 3'h1;
                  end
                end
              endcase
            end
            else
            begin
              case (q)
                2'h0: bus.host_sda_oen <= 1'b0;
                2'h1: bus.host_scl_oen <= 1'b1;
                2'h2: bus.host_sda_oen <= 1'b1;
                default: state <= H_IDLE;
              endcase
            end
          end
        end
        default:
          state <= H_IDLE;
      endcase
    end
  end

  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_wake_o = 1'b0;
endmodule

// [pib_props.sv]
// Checker for the shared clock, data and wake lines between the host and the controller.
`timescale 1ns/1ns
module pib_props
#(
  parameter int SLEEP_CYCLES = 200,
  parameter int WAKE_CYCLES = 80
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic host_scl_o,
  input wire logic host_scl_oen,
  input wire logic host_sda_o,
  input wire logic host_sda_oen,
  input wire logic host_wake_o,
  input wire logic host_wake_oen,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oen,
  input wire logic dev_wake_o,
  input wire logic dev_wake_oen,
  input wire logic scl,
  input wire logic sda,
  input wire logic wake
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  int wlow;
  int quiet;
  logic scl_q;
  logic sda_q;
  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Quiet time is counted from the raw lines, so the controller's synchroniser gets some slack.
  always_ff @(posedge aclk)
  begin
    scl_q <= scl;
    sda_q <= sda;
    if (!aresetn || host_wake_oen)
      wlow <= 0;
    else
      wlow <= wlow + 1;
    if (!aresetn || !wake || scl != scl_q || sda != sda_q)
      quiet <= 0;
    else if (quiet < SLEEP_CYCLES + 100)
      quiet <= quiet + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////////////////////
  open_drain_only_a: assert property (!host_wake_o && !dev_wake_o && !dev_sda_o && !host_sda_o)
    else $error("line driven high instead of released");
  sda_release_a: assert property ($fell(dev_sda_oen) |-> ##[1:250] dev_sda_oen)
    else $error("controller held data low too long");
  dev_sda_scl_low_a: assert property ($changed(dev_sda_oen) |-> !scl)
    else $error("controller changed data while clock high");
  wake_pulse_width_a: assert property ($rose(host_wake_oen) |-> wlow >= WAKE_CYCLES)
    else $error("wake pulse too short");
  asleep_no_ack_a: assert property (quiet > SLEEP_CYCLES + 8 |-> dev_sda_oen)
    else $error("controller pulled data after sleep time");
  wake_pull_hold_a: assert property ($fell(dev_wake_oen) |=> !dev_wake_oen [*8])
    else $error("latched wake pull too short");
  quiet_during_wake_a: assert property (!host_wake_oen |-> scl && sda)
    else $error("bus traffic during wake pulse");
  idle_after_reset_a: assert property ($rose(aresetn) |-> dev_sda_oen && dev_wake_oen && host_scl_oen)
    else $error("lines not released after reset");
  cover property ($rose(host_wake_oen));
  cover property ($fell(dev_sda_oen));
  cover property ($fell(dev_wake_oen));
  cover property (quiet == SLEEP_CYCLES + 10);
endmodule

// [tb_top.sv]
// Self-checking bench: host and controller joined over the shared link, driven over AXI4-Lite.
`timescale 1ns/1ns
module tb_top
  import pib_pkg::*;
();
  localparam int SLP = 200;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = '0, araddr = '0, wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [2:0] irq_src = 3'h0;
  logic latched_mode = 1'b0;
  logic awake, inertial_power, environment_power, microphone_power, air_quality_power;
  logic air_quality_wake, led_regulator_en;
  logic [3:0] led_en;
  int miscompares = 0;
  int tests_run = 0;
  int m [0:7];
  int f, c, d;
  logic [7:0] rb;
  logic [31:0] s;
  logic [1:0] r;
  ////////////////////////////////////////////////////////////////////////////////////////////////
  pib_if link();
  pib_host #(.QUARTER_CYCLES(QUARTER_CYC), .WAKE_CYCLES(WAKE_CYC)) pib_host_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .bus(link.host));
  pib_device #(.SLEEP_CYCLES(SLP)) pib_device_inst (
    .aclk(aclk), .aresetn(aresetn), .bus(link.dev), .irq_src(irq_src),
    .latched_mode(latched_mode), .awake(awake), .inertial_power(inertial_power),
    .environment_power(environment_power), .microphone_power(microphone_power),
    .air_quality_power(air_quality_power), .air_quality_wake(air_quality_wake),
    .led_regulator_en(led_regulator_en), .led_en(led_en));
  pib_props #(.SLEEP_CYCLES(SLP), .WAKE_CYCLES(WAKE_CYC)) pib_props_inst (
    .aclk(aclk), .aresetn(aresetn), .host_scl_o(link.host_scl_o),
    .host_scl_oen(link.host_scl_oen), .host_sda_o(link.host_sda_o),
    .host_sda_oen(link.host_sda_oen), .host_wake_o(link.host_wake_o),
    .host_wake_oen(link.host_wake_oen), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oen(link.dev_sda_oen), .dev_wake_o(link.dev_wake_o),
    .dev_wake_oen(link.dev_wake_oen), .scl(link.scl), .sda(link.sda), .wake(link.wake));
  ////////////////////////////////////////////////////////////////////////////////////////////////
  always #25 aclk = ~aclk;
  // Readies and answers are read at the edge itself, before that edge's updates land.
  task automatic tick();
    @(posedge aclk);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] dt, output logic [1:0] rs);
    awaddr <= a;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do tick(); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (!bvalid) tick();
    rs = bresp;
    bready <= 1'b0;
    tick();
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] dt, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do tick(); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) tick();
    dt = rdata;
    rs = rresp;
    rready <= 1'b0;
    tick();
  endtask
  // One link command: wake pulse, transfer, then poll until the host is idle.
  task automatic cmd(input logic [1:0] op, input logic [7:0] ra, input logic [7:0] wd);
    axi_wr(CMD_OFS, {8'h00, wd, ra, 6'h00, op}, r);
    check(r, RESP_OKAY, "command response");
    do axi_rd(STAT_OFS, s, r); while (s[0] === 1'b1);
    check(s[1], 1'b0, "controller refused transfer");
    rb = s[15:8];
  endtask
  task automatic reg_rd(input int a, input int exp);
    cmd(OP_READ, a[7:0], 8'h00);
    check(rb, exp[7:0], "register read");
  endtask
  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (90000) @(posedge aclk);
    miscompares++;
    $display("FAIL %0t watchdog expired", $time);
    stop_test();
  end
  initial
  begin
    void'($urandom(32'h61285fb9));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    tick();
    for (int i = 0; i < 8; i++)
      reg_rd(i, 0);
    $display("Test reset values finished");
    for (int p = 0; p < 2; p++)
    begin
      for (int i = 0; i < NUM_CTRL; i++)
      begin
        d = $urandom;
        m[i] = d & int'(WMASK[i]);
        cmd(OP_WRITE, i[7:0], d[7:0]);
      end
      for (int i = 0; i < NUM_CTRL; i++)
        reg_rd(i, m[i]);
      check({led_en, led_regulator_en, air_quality_wake, air_quality_power, microphone_power,
        environment_power, inertial_power}, {m[4][7:4], m[4][0], m[3][1], m[3][0], m[2][0],
        m[1][0], m[0][0]}, "power outputs");
    end
    $display("Test control registers finished");
    axi_rd(CMD_OFS, s, r);
    check(s, {16'h0000, 8'(NUM_CTRL - 1), 6'h00, OP_READ}, "command readback");
    axi_wr(CMD_OFS, 32'h0, r);
    axi_rd(STAT_OFS, s, r);
    check(s[0], 1'b0, "empty command ignored");
    axi_rd(4'h8, s, r);
    check(s, 32'h0, "unmapped read");
    check(r, RESP_SLVERR, "unmapped response");
    axi_wr(STAT_OFS, 32'h0, r);
    check(r, RESP_SLVERR, "status write");
    $display("Test host map finished");
    f = $urandom_range(7, 1);
    irq_src <= f[2:0];
    repeat (4) tick();
    irq_src <= 3'h0;
    cmd(OP_WRITE, REG_IRQ_STATUS, 8'hff);
    reg_rd(7, f);
    cmd(OP_WRITE, REG_IRQ_CLEAR, 8'h00);
    reg_rd(7, f);
    reg_rd(6, 0);
    latched_mode <= 1'b1;
    cmd(OP_WRITE, REG_IRQ_ENABLE, 8'h07);
    repeat (SLP * 2) tick();
    check(awake, 1'b1, "awake while line held");
    axi_rd(STAT_OFS, s, r);
    check(s[2], 1'b1, "latched pull");
    c = f & -f;
    cmd(OP_WRITE, REG_IRQ_CLEAR, c[7:0]);
    f = f & ~c;
    reg_rd(7, f);
    cmd(OP_WRITE, REG_IRQ_CLEAR, 8'h07);
    reg_rd(7, 0);
    repeat (10) tick();
    axi_rd(STAT_OFS, s, r);
    check(s[2], 1'b0, "pull released");
    $display("Test interrupt flags finished");
    repeat (SLP + 50) tick();
    check(awake, 1'b0, "asleep after quiet time");
    cmd(OP_WAKE, 8'h00, 8'h00);
    check(awake, 1'b1, "woken by pulse");
    $display("Test sleep and wake finished");
    stop_test();
  end
endmodule
